//--- hw/bfo_params.svh
// Constants for the bit-oriented file-register instruction block
`ifndef BFO_PARAMS_SVH
`define BFO_PARAMS_SVH

`define BFO_INSTR_W     14
`define BFO_DATA_W      8
`define BFO_ADDR_W      7
`define BFO_BITSEL_W    3
`define BFO_CLASS_HI    13
`define BFO_CLASS_LO    12
`define BFO_SEL_HI      11
`define BFO_SEL_LO      10
`define BFO_BIT_HI      9
`define BFO_BIT_LO      7
`define BFO_ADDR_HI     6
`define BFO_ADDR_LO     0
`define BFO_CLASS_BITOP 2'h1
`define BFO_SEL_CLR     2'h0
`define BFO_SEL_SET     2'h1
`define BFO_SEL_TST     2'h2
`define BFO_CYC_BITOP   1
`define BFO_CYC_SKIP    2

`endif

//--- hw/bfo_pkg.sv
// Types shared by the bit-oriented instruction block
`default_nettype none

package bfo_pkg;
  typedef enum logic [1:0] {
    BFO_OP_NONE,
    BFO_OP_CLR,
    BFO_OP_SET,
    BFO_OP_TST
  } bfo_op_t;
endpackage

`default_nettype wire

//--- hw/bfo_mem_if.sv
// Port bundle between the execution logic and the file register memory
`default_nettype none

interface bfo_mem_if #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 7
);
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [ADDR_W-1:0] peek_addr;
  logic [DATA_W-1:0] peek_data;

  modport core (
    output rd_addr, wr_en, wr_addr, wr_data, peek_addr,
    input  rd_data, peek_data
  );
  modport mem (
    input  rd_addr, wr_en, wr_addr, wr_data, peek_addr,
    output rd_data, peek_data
  );
endinterface

`default_nettype wire

//--- hw/bfo_file_mem.sv
// File register memory: one write port, two registered read ports
`default_nettype none

module bfo_file_mem #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 7
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  bfo_mem_if.mem    m
);
  logic [DATA_W-1:0] mem_array [2**ADDR_W];

  always_ff @(posedge clk_i) begin
    if (m.wr_en) begin
      mem_array[m.wr_addr] <= m.wr_data;
    end
  end

  // Write-first bypass so back-to-back ops on one address see new data
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      m.rd_data <= '0;
    end else if (m.wr_en && (m.wr_addr == m.rd_addr)) begin
      m.rd_data <= m.wr_data;
    end else begin
      m.rd_data <= mem_array[m.rd_addr];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      m.peek_data <= '0;
    end else if (m.wr_en && (m.wr_addr == m.peek_addr)) begin
      m.peek_data <= m.wr_data;
    end else begin
      m.peek_data <= mem_array[m.peek_addr];
    end
  end
endmodule

`default_nettype wire

//--- hw/bfo_core.sv
// Execution of clear-bit, set-bit and test-bit-skip-if-zero instructions
`include "bfo_params.svh"
`default_nettype none

module bfo_core #(
  parameter int DATA_W = `BFO_DATA_W,
  parameter int ADDR_W = `BFO_ADDR_W
) (
  input  wire logic                   clk_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   instr_valid_i,
  input  wire logic [`BFO_INSTR_W-1:0] instr_i,
  input  wire logic                   ext_wr_en_i,
  input  wire logic [ADDR_W-1:0]      ext_wr_addr_i,
  input  wire logic [DATA_W-1:0]      ext_wr_data_i,
  output logic                        ext_wr_ready_o,
  input  wire logic [ADDR_W-1:0]      peek_addr_i,
  output logic [DATA_W-1:0]           peek_data_o,
  output logic                        skip_o,
  output logic                        done_o,
  output bfo_pkg::bfo_op_t            done_op_o,
  output logic [ADDR_W-1:0]           done_addr_o
);
  import bfo_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Reset release
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////
  // Memory
  bfo_mem_if #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) mem_bus ();

  bfo_file_mem #(
    .DATA_W (DATA_W),
    .ADDR_W (ADDR_W)
  ) u_mem (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .m       (mem_bus.mem)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decode stage
  logic [1:0]              fld_class;
  logic [1:0]              fld_sel;
  logic [`BFO_BITSEL_W-1:0] fld_bit;
  logic [ADDR_W-1:0]       fld_addr;
  bfo_op_t                 dec_op;
  bfo_op_t                 s1_op;

  assign fld_class = instr_i[`BFO_CLASS_HI:`BFO_CLASS_LO];
  assign fld_sel   = instr_i[`BFO_SEL_HI:`BFO_SEL_LO];
  assign fld_bit   = instr_i[`BFO_BIT_HI:`BFO_BIT_LO];
  assign fld_addr  = instr_i[`BFO_ADDR_HI:`BFO_ADDR_LO];

  always_comb begin
    dec_op = BFO_OP_NONE;
    if (fld_class == `BFO_CLASS_BITOP) begin
      case (fld_sel)
        `BFO_SEL_CLR: dec_op = BFO_OP_CLR;
        `BFO_SEL_SET: dec_op = BFO_OP_SET;
        `BFO_SEL_TST: dec_op = BFO_OP_TST;
        default:      dec_op = BFO_OP_NONE;
      endcase
    end
  end

  // Word fetched during a failing test runs as a nop
  assign s1_op = (instr_valid_i && !skip_o) ? dec_op : BFO_OP_NONE;

  assign mem_bus.rd_addr   = fld_addr;
  assign mem_bus.peek_addr = peek_addr_i;
  assign peek_data_o       = mem_bus.peek_data;

  ////////////////////////////////////////////////////////////////////////
  // Execute stage registers
  bfo_op_t                  s2_op_reg;
  logic [`BFO_BITSEL_W-1:0] s2_bit_reg;
  logic [ADDR_W-1:0]        s2_addr_reg;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s2_op_reg   <= BFO_OP_NONE;
      s2_bit_reg  <= '0;
      s2_addr_reg <= '0;
    end else begin
      s2_op_reg   <= s1_op;
      s2_bit_reg  <= fld_bit;
      s2_addr_reg <= fld_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read-modify-write
  logic [DATA_W-1:0] rd_val;
  logic [DATA_W-1:0] mod_val;
  logic              bit_wr;
  logic              tested_bit;

  assign rd_val     = mem_bus.rd_data;
  assign tested_bit = rd_val[s2_bit_reg];
  assign bit_wr     = (s2_op_reg == BFO_OP_CLR) || (s2_op_reg == BFO_OP_SET);

  generate
    for (genvar i = 0; i < DATA_W; i++) begin : g_bit
      // Only the selected bit follows the op, the rest are kept
      assign mod_val[i] = (s2_bit_reg == `BFO_BITSEL_W'(i)) ?
                          (s2_op_reg == BFO_OP_SET) : rd_val[i];
    end
  endgenerate

  // Bit ops own the write port; other writers wait on ready
  assign ext_wr_ready_o  = !bit_wr;
  assign mem_bus.wr_en   = bit_wr || ext_wr_en_i;
  assign mem_bus.wr_addr = bit_wr ? s2_addr_reg : ext_wr_addr_i;
  assign mem_bus.wr_data = bit_wr ? mod_val : ext_wr_data_i;

  assign skip_o = (s2_op_reg == BFO_OP_TST) && !tested_bit;

  ////////////////////////////////////////////////////////////////////////
  // Completion report
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      done_o      <= 1'b0;
      done_op_o   <= BFO_OP_NONE;
      done_addr_o <= '0;
    end else begin
      done_o      <= (s2_op_reg != BFO_OP_NONE);
      done_op_o   <= s2_op_reg;
      done_addr_o <= s2_addr_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  a_clear_bit_zero: assert property (
    s2_op_reg == BFO_OP_CLR |->
      mem_bus.wr_en && !mem_bus.wr_data[s2_bit_reg] &&
      ((mem_bus.wr_data | (DATA_W'(1) << s2_bit_reg)) ==
       (rd_val | (DATA_W'(1) << s2_bit_reg)))
  ) else $error("clear did not clear only the chosen bit");

  a_set_bit_one: assert property (
    s2_op_reg == BFO_OP_SET |->
      mem_bus.wr_en && mem_bus.wr_data[s2_bit_reg] &&
      (mem_bus.wr_addr == s2_addr_reg) &&
      ((mem_bus.wr_data & ~(DATA_W'(1) << s2_bit_reg)) ==
       (rd_val & ~(DATA_W'(1) << s2_bit_reg)))
  ) else $error("set did not set only the chosen bit");

  a_test_skip_zero: assert property (
    s2_op_reg == BFO_OP_TST |->
      (skip_o == !rd_val[s2_bit_reg]) && ext_wr_ready_o
  ) else $error("test skip decision or write wrong");

  a_skip_drops_next: assert property (
    skip_o |=> s2_op_reg == BFO_OP_NONE ##1 !done_o
  ) else $error("word after failing test was executed");

  a_skip_two_cycles: assert property (
    instr_valid_i && !skip_o && dec_op == BFO_OP_TST ##1 skip_o
      |=> !skip_o
  ) else $error("skip lasted more than one cycle");

  a_single_cycle_op: assert property (
    instr_valid_i && !skip_o && (dec_op == BFO_OP_CLR ||
      dec_op == BFO_OP_SET) |=> bit_wr ##1 done_o && done_op_o ==
      $past(s2_op_reg)
  ) else $error("bit op did not complete in one cycle");

  a_decode_fields: assert property (
    instr_valid_i && !skip_o && fld_class == `BFO_CLASS_BITOP &&
      fld_sel != 2'h3 |=> s2_op_reg != BFO_OP_NONE &&
      s2_addr_reg == $past(instr_i[`BFO_ADDR_HI:`BFO_ADDR_LO]) &&
      s2_bit_reg == $past(instr_i[`BFO_BIT_HI:`BFO_BIT_LO])
  ) else $error("operand fields decoded wrongly");

  a_other_class_idle: assert property (
    fld_class != `BFO_CLASS_BITOP |=> s2_op_reg == BFO_OP_NONE
  ) else $error("foreign instruction started a bit op");

  a_done_reports_op: assert property (
    s2_op_reg != BFO_OP_NONE |=> done_o &&
      done_op_o == $past(s2_op_reg) && done_addr_o == $past(s2_addr_reg)
  ) else $error("completion report does not match executed op");

  a_skip_only_test: assert property (
    skip_o |-> s2_op_reg == BFO_OP_TST && !bit_wr
  ) else $error("skip raised outside a failing test");

  a_bit_op_owns_port: assert property (
    bit_wr |-> !ext_wr_ready_o && mem_bus.wr_addr == s2_addr_reg
  ) else $error("bit op lost the write port");

  a_idle_no_done: assert property (
    s2_op_reg == BFO_OP_NONE |=> !done_o
  ) else $error("completion reported without an op");

  c_clear_op: cover property (s2_op_reg == BFO_OP_CLR);
  c_set_op: cover property (s2_op_reg == BFO_OP_SET);
  c_test_skip: cover property (skip_o);
  c_test_no_skip: cover property (s2_op_reg == BFO_OP_TST && !skip_o);
  c_back_to_back: cover property (
    bit_wr && s1_op != BFO_OP_NONE && fld_addr == s2_addr_reg
  );
endmodule

`default_nettype wire

//--- verification/bfo_tb.sv
// Self-checking random bench for the bit-oriented instruction block
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bfo_pkg::*;

  `define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin \
    num_errors++; $display("ERROR %s exp %0h got %0h", n, e, s); end end

  logic        clk_i         = 1'h0;
  logic        reset_n_i     = 1'h0;
  logic        instr_valid_i = 1'h0;
  logic        ext_wr_en_i   = 1'h0;
  logic [13:0] instr_i       = 14'h0;
  logic [6:0]  ext_wr_addr_i = 7'h0;
  logic [6:0]  peek_addr_i   = 7'h0;
  logic [7:0]  ext_wr_data_i = 8'h0;
  logic        ext_wr_ready_o;
  logic        skip_o;
  logic        done_o;
  bfo_op_t     done_op_o;
  logic [6:0]  done_addr_o;
  logic [7:0]  peek_data_o;
  logic [7:0]  mem [128];
  logic [31:0] seed          = 32'h7C5F;
  int          num_errors    = 0;
  int          tests_run     = 0;

  bfo_core i_dut (
    .clk_i         (clk_i),
    .reset_n_i     (reset_n_i),
    .instr_valid_i (instr_valid_i),
    .instr_i       (instr_i),
    .ext_wr_en_i   (ext_wr_en_i),
    .ext_wr_addr_i (ext_wr_addr_i),
    .ext_wr_data_i (ext_wr_data_i),
    .ext_wr_ready_o(ext_wr_ready_o),
    .peek_addr_i   (peek_addr_i),
    .peek_data_o   (peek_data_o),
    .skip_o        (skip_o),
    .done_o        (done_o),
    .done_op_o     (done_op_o),
    .done_addr_o   (done_addr_o)
  );

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] after_op(logic [1:0] sel, logic [7:0] d,
                                          logic [2:0] b);
    logic [7:0] r;
    r = d;
    if (sel == 2'h0) r[b] = 1'h0;
    if (sel == 2'h1) r[b] = 1'h1;
    return r;
  endfunction

  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask

  task automatic wrap_up();
    if (num_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Word in c0, then a set on the same address or the one with bit 0 flipped that a skip must eat
  task automatic exec(logic [1:0] cls, logic [1:0] sel, logic [2:0] b,
                      logic [6:0] a);
    logic       hit;
    logic       sk;
    logic [6:0] nb;
    hit = (cls == 2'h1) && (sel != 2'h3);
    sk = hit && (sel == 2'h2) && !mem[a][b];
    nb = a ^ {6'h00, b[0]};
    instr_valid_i = 1'h1;
    instr_i = {cls, sel, b, a};
    peek_addr_i = a;
    tick();
    `CHK("skip", sk, skip_o)
    `CHK("ready", !(hit && sel != 2'h2), ext_wr_ready_o)
    instr_i = {2'h1, 2'h1, 3'h0, nb};
    tick();
    `CHK("done", hit, done_o)
    if (hit) `CHK("op", bfo_op_t'(sel + 2'h1), done_op_o)
    if (hit) `CHK("addr", a, done_addr_o)
    if (hit) mem[a] = after_op(sel, mem[a], b);
    `CHK("peek", mem[a], peek_data_o)
    instr_valid_i = 1'h0;
    peek_addr_i = nb;
    if (!sk) mem[nb][0] = 1'h1;
    tick();
    `CHK("follow_done", !sk, done_o)
    if (!sk) `CHK("follow_addr", nb, done_addr_o)
    `CHK("follow_peek", mem[nb], peek_data_o)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    repeat (16) @(posedge clk_i);
    #1 reset_n_i = 1'h1;
    `CHK("rst_done", 1'h0, done_o)
    `CHK("rst_skip", 1'h0, skip_o)
    `CHK("rst_ready", 1'h1, ext_wr_ready_o)
    repeat (3) tick();
    ext_wr_en_i = 1'h1;
    for (int i = 0; i < 128; i++) begin
      ext_wr_addr_i = 7'(i);
      ext_wr_data_i = 8'(rnd());
      mem[i] = ext_wr_data_i;
      tick();
    end
    ext_wr_en_i = 1'h0;
    // Corners: edge address and bits, both test outcomes, ignored words
    exec(2'h1, 2'h0, 3'h7, 7'h7F);
    exec(2'h1, 2'h2, 3'h7, 7'h7F);
    exec(2'h1, 2'h1, 3'h0, 7'h00);
    exec(2'h1, 2'h2, 3'h0, 7'h00);
    exec(2'h1, 2'h3, 3'h3, 7'h10);
    exec(2'h0, 2'h0, 3'h3, 7'h10);
    for (int i = 0; i < 300; i++) begin
      r = rnd();
      exec(r[4] ? 2'h1 : r[6:5], r[8:7], r[11:9], r[18:12]);
    end
    wrap_up();
  end

  initial begin
    #50000;
    num_errors++;
    wrap_up();
  end

endmodule

`default_nettype wire
